// *** hdl/rotate_right_thru_cy_op.sv ***
// rotate right through carry, executed over four internal phases
`timescale 1ns/1ps
module rotate_right_thru_cy_op #(
    parameter int ADDR_W = rotate_exec_pkg::ADDR_W_DEF,
    parameter int BANK_W = rotate_exec_pkg::BANK_W_DEF
) (
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire logic i_start,
    input wire logic [rotate_exec_pkg::DATA_W-1:0] i_f_operand,
    input wire logic i_dest_sel,
    input wire logic i_bank_sel,
    input wire logic i_ext_set_en,
    input wire logic [BANK_W-1:0] i_bank_base_ptr,
    input wire logic [ADDR_W-1:0] i_index_base,
    input wire logic i_carry,
    input wire logic [rotate_exec_pkg::DATA_W-1:0] i_mem_rdata,
    output logic o_busy,
    output logic [ADDR_W-1:0] o_mem_addr,
    output logic o_mem_rd,
    output logic o_mem_wr,
    output logic [rotate_exec_pkg::DATA_W-1:0] o_mem_wdata,
    output logic o_acc_wr,
    output logic [rotate_exec_pkg::DATA_W-1:0] o_acc_wdata,
    output logic o_carry,
    output logic o_negative,
    output logic o_zero,
    output logic o_status_wr,
    output logic o_indexed,
    output logic o_done
);
    import rotate_exec_pkg::*;

    // the address is a bank above an 8-bit operand, nothing else fits
    generate
        if (ADDR_W != BANK_W + DATA_W) begin : g_bad_width
            $error("address width must be bank width plus eight");
        end
    endgenerate

    // returns {new carry, rotated byte}
    function automatic logic [DATA_W:0] rotate_thru(
        input logic [DATA_W-1:0] value,
        input logic carry_in
    );
        // old carry enters at the top, bit 0 leaves as carry
        return {value[LSB_POS], carry_in,
            value[MSB_POS:LSB_POS+1]}; // see RULE7
    endfunction : rotate_thru

    phase_t state_reg; // current phase
    phase_t state_next; // phase after this edge
    logic [DATA_W-1:0] f_reg; // latched register operand
    logic dest_reg; // latched destination select
    logic bank_reg; // latched bank select
    logic ext_reg; // latched extended set enable
    logic cin_reg; // carry as it stood at the start
    logic [BANK_W-1:0] bptr_reg; // latched bank base pointer
    logic [ADDR_W-1:0] ibase_reg; // latched index base
    logic [DATA_W-1:0] rdata_reg; // operand as read, kept for the checks

    wire [ADDR_W-1:0] res_addr; // resolved address of the operand
    wire res_indexed; // resolved in indexed literal offset mode

    // operand and status are held from start, so later input changes
    // cannot disturb an instruction already in flight
    wire take = (state_reg == PH_IDLE) && i_start;
    wire in_decode = (state_reg == PH_DECODE);
    wire in_process = (state_reg == PH_PROCESS);
    // rotated value from the data returned during the process phase
    wire [DATA_W:0] rot_now = rotate_thru(i_mem_rdata, cin_reg); // see RULE1
    wire [DATA_W-1:0] rot_byte = rot_now[DATA_W-1:0];
    wire rot_cy = rot_now[DATA_W];
    wire to_acc = (dest_reg == DEST_ACC); // see RULE2
    wire to_file = (dest_reg == DEST_FILE); // see RULE3

    operand_addr_resolve #(
        .ADDR_W(ADDR_W),
        .BANK_W(BANK_W)
    ) u_resolve (
        .i_f_operand(f_reg),
        .i_bank_sel(bank_reg),
        .i_ext_set_en(ext_reg),
        .i_bank_base_ptr(bptr_reg),
        .i_index_base(ibase_reg),
        .o_addr(res_addr),
        .o_indexed(res_indexed)
    );

    // phase sequencing: decode, read, process, write, then idle
    always_comb begin
        case (state_reg)
            PH_IDLE: begin
                state_next = i_start ? PH_DECODE : PH_IDLE;
            end
            PH_DECODE: begin
                state_next = PH_READ;
            end
            PH_READ: begin
                state_next = PH_PROCESS;
            end
            PH_PROCESS: begin
                state_next = PH_WRITE;
            end
            PH_WRITE: begin
                state_next = PH_IDLE;
            end
            default: begin
                state_next = PH_IDLE;
            end
        endcase
    end

    // phase register
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            state_reg <= PH_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // operand latch on acceptance
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            f_reg <= '0;
            dest_reg <= DEST_FILE;
            bank_reg <= BANK_PTR;
            ext_reg <= 1'b0;
            cin_reg <= 1'b0;
            bptr_reg <= '0;
            ibase_reg <= '0;
        end else if (take) begin
            f_reg <= i_f_operand;
            dest_reg <= i_dest_sel;
            bank_reg <= i_bank_sel;
            ext_reg <= i_ext_set_en;
            cin_reg <= i_carry;
            bptr_reg <= i_bank_base_ptr;
            ibase_reg <= i_index_base;
        end
    end

    // busy from acceptance until the write phase ends
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            o_busy <= 1'b0;
        end else begin
            o_busy <= (state_next != PH_IDLE);
        end
    end

    // read request for the read phase; address held to the end
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            o_mem_addr <= '0;
            o_indexed <= 1'b0;
            o_mem_rd <= 1'b0;
        end else begin
            o_mem_rd <= in_decode;
            if (in_decode) begin
                o_mem_addr <= res_addr; // see RULE4
                o_indexed <= res_indexed; // see RULE6
            end
        end
    end

    // keep the byte as read, the memory need not hold it
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            rdata_reg <= '0;
        end else if (in_process) begin
            rdata_reg <= i_mem_rdata;
        end
    end

    // write strobes: exactly one destination per instruction
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            o_mem_wr <= 1'b0;
            o_acc_wr <= 1'b0;
            o_status_wr <= 1'b0;
            o_done <= 1'b0;
        end else begin
            o_mem_wr <= in_process && to_file; // see RULE3
            o_acc_wr <= in_process && to_acc; // see RULE2
            o_status_wr <= in_process;
            o_done <= in_process;
        end
    end

    // result and flags; the data buses keep their last value afterwards
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            o_mem_wdata <= '0;
            o_acc_wdata <= '0;
            o_carry <= 1'b0;
            o_negative <= 1'b0;
            o_zero <= 1'b0;
        end else if (in_process) begin
            if (to_file) begin
                o_mem_wdata <= rot_byte; // see RULE3
            end
            if (to_acc) begin
                o_acc_wdata <= rot_byte; // see RULE2
            end
            o_carry <= rot_cy; // see RULE7
            o_negative <= rot_byte[MSB_POS];
            o_zero <= (rot_byte == BYTE_ZERO);
        end
    end

    // checks on phase order, addresses and results
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_reset);

    // expected rotate from the stored operand and starting carry
    wire [DATA_W:0] rot_chk = rotate_thru(rdata_reg, cin_reg);

    sequence s_phases;
        (state_reg == PH_DECODE) ##1 (state_reg == PH_READ)
            ##1 (state_reg == PH_PROCESS) ##1 (state_reg == PH_WRITE)
            ##1 (state_reg == PH_IDLE);
    endsequence

    sequence s_read_then_done;
        o_mem_rd ##2 o_done;
    endsequence

    a_phase_order: assert property (take |=> s_phases) // see RULE1
        else $error("phases did not run decode read process write");

    a_read_to_write: assert property ( // see RULE1
        take |-> ##2 s_read_then_done)
        else $error("read or done strobe out of place");

    a_rotate_value: assert property ( // see RULE1
        o_done |-> (to_file ? o_mem_wdata : o_acc_wdata)
            == {cin_reg, rdata_reg[MSB_POS:LSB_POS+1]})
        else $error("rotated byte is wrong");

    a_acc_only: assert property ( // see RULE2
        o_done && to_acc |-> o_acc_wr && !o_mem_wr)
        else $error("accumulator destination wrote the file register");

    a_file_back: assert property ( // see RULE3
        o_done && to_file |->
        o_mem_wr && !o_acc_wr && o_mem_wdata == rot_chk[DATA_W-1:0])
        else $error("file destination not written back");

    a_direct_bank: assert property ( // see RULE4
        o_mem_rd && !bank_reg && !(ext_reg && f_reg <= ACCESS_LIMIT) |->
        o_mem_addr == {((f_reg <= ACCESS_LIMIT) ? BANK_W'(ACCESS_LO_BANK)
            : BANK_W'(ACCESS_HI_BANK)), f_reg})
        else $error("direct bank address wrong");

    a_bank_pointer: assert property ( // see RULE5
        o_mem_rd && bank_reg |->
        o_mem_addr == {bptr_reg, f_reg} && !o_indexed)
        else $error("bank pointer address wrong");

    a_indexed_mode: assert property ( // see RULE6
        o_mem_rd && !bank_reg && ext_reg
        && f_reg <= ACCESS_LIMIT |-> o_indexed && o_mem_addr ==
        ADDR_W'(ibase_reg + {{(ADDR_W-DATA_W){1'b0}}, f_reg}))
        else $error("indexed literal offset address wrong");

    // old carry must land in bit 7 of whichever destination was written
    a_carry_move: assert property ( // see RULE7
        o_done |-> o_carry == rdata_reg[LSB_POS] && o_status_wr
        && (to_file ? o_mem_wdata[MSB_POS] : o_acc_wdata[MSB_POS])
            == cin_reg)
        else $error("carry did not move through the rotate");
endmodule : rotate_right_thru_cy_op

// *** hdl/rotate_exec_pkg.sv ***
// constants, phase states and widths for the rotate-through-carry step
// What this block does
// RULE1: rotate selected register right one, through carry
// RULE2: destination select 0 writes accumulator only
// RULE3: destination select 1 writes source register back
// RULE4: bank select 0 resolves inside direct bank
// RULE5: bank select 1 uses bank base pointer
// RULE6: extended set, bank 0, operand up to 5fh: indexed
// RULE7: old carry to bit 7, bit 0 to carry
package rotate_exec_pkg;
    // data path width of the file registers and accumulator
    localparam int DATA_W = 8;
    // default widths of bank pointer and full data address
    localparam int BANK_W_DEF = 4;
    localparam int ADDR_W_DEF = 12;
    // highest operand that stays in the low part of the direct bank
    localparam logic [7:0] ACCESS_LIMIT = 8'h5f;
    // bank used for the low part of the direct bank
    localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
    // bank used for the upper part (special registers) of the direct bank
    localparam logic [3:0] ACCESS_HI_BANK = 4'hf;
    // operand select values
    localparam logic DEST_ACC = 1'b0;
    localparam logic DEST_FILE = 1'b1;
    localparam logic BANK_DIRECT = 1'b0;
    localparam logic BANK_PTR = 1'b1;
    // bit positions inside the byte
    localparam int MSB_POS = 7;
    localparam int LSB_POS = 0;
    // value of an all-clear byte, used for the zero flag
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    // four internal phases plus idle, gray coded from idle through write; the return to idle flips two bits
    typedef enum logic [2:0] {
        PH_IDLE    = 3'h0,
        PH_DECODE  = 3'h1,
        PH_READ    = 3'h3,
        PH_PROCESS = 3'h2,
        PH_WRITE   = 3'h6
    } phase_t;
endpackage : rotate_exec_pkg

// *** hdl/operand_addr_resolve.sv ***
// combinational resolution of the 8-bit operand to a data address
`timescale 1ns/1ps
module operand_addr_resolve #(
    parameter int ADDR_W = rotate_exec_pkg::ADDR_W_DEF,
    parameter int BANK_W = rotate_exec_pkg::BANK_W_DEF
) (
    input wire logic [rotate_exec_pkg::DATA_W-1:0] i_f_operand,
    input wire logic i_bank_sel,
    input wire logic i_ext_set_en,
    input wire logic [BANK_W-1:0] i_bank_base_ptr,
    input wire logic [ADDR_W-1:0] i_index_base,
    output logic [ADDR_W-1:0] o_addr,
    output logic o_indexed
);
    import rotate_exec_pkg::*;

    // operand sits in the low half of the direct bank
    wire low_half = (i_f_operand <= ACCESS_LIMIT);
    // indexed literal offset only with direct bank and extended set
    wire use_index = (i_bank_sel == BANK_DIRECT) && i_ext_set_en
        && low_half; // see RULE6
    // index base plus operand, wraps inside the address space
    wire [ADDR_W-1:0] index_addr = ADDR_W'(i_index_base
        + {{(ADDR_W-DATA_W){1'b0}}, i_f_operand}); // see RULE6
    // pointer selects the general bank holding the operand
    wire [ADDR_W-1:0] bank_addr = {i_bank_base_ptr, i_f_operand}; // see RULE5
    // direct bank: low half at bank 0, upper half at the top bank
    wire [BANK_W-1:0] direct_bank = low_half ? BANK_W'(ACCESS_LO_BANK)
        : BANK_W'(ACCESS_HI_BANK);
    // pointer is never consulted here
    wire [ADDR_W-1:0] direct_addr = {direct_bank, i_f_operand}; // see RULE4

    // priority: pointer, then indexed, then plain direct
    assign o_addr = (i_bank_sel == BANK_PTR) ? bank_addr
        : (use_index ? index_addr : direct_addr);
    assign o_indexed = use_index;
endmodule : operand_addr_resolve

// *** tb/testbench.sv ***
// self-checking bench for the rotate-through-carry execution block
`timescale 1ns/1ps
module testbench;
    import rotate_exec_pkg::*;
    logic i_core_clk; // 20 mhz core clock
    logic i_reset; // synchronous, active high
    logic i_start;
    logic [7:0] i_f_operand;
    logic i_dest_sel;
    logic i_bank_sel;
    logic i_ext_set_en;
    logic [3:0] i_bank_base_ptr;
    logic [11:0] i_index_base;
    logic i_carry;
    logic [7:0] i_mem_rdata; // inverse of the byte outside the read slot
    logic o_busy, o_mem_rd, o_mem_wr, o_acc_wr, o_carry, o_negative;
    logic o_zero, o_status_wr, o_indexed, o_done;
    logic [11:0] o_mem_addr;
    logic [7:0] o_mem_wdata, o_acc_wdata;
    int mismatches; // count of wrong values
    int n_checks; // count of comparisons

    rotate_right_thru_cy_op uut (.i_core_clk(i_core_clk), .i_reset(i_reset),
        .i_start(i_start), .i_f_operand(i_f_operand),
        .i_dest_sel(i_dest_sel), .i_bank_sel(i_bank_sel),
        .i_ext_set_en(i_ext_set_en), .i_bank_base_ptr(i_bank_base_ptr),
        .i_index_base(i_index_base), .i_carry(i_carry),
        .i_mem_rdata(i_mem_rdata), .o_busy(o_busy),
        .o_mem_addr(o_mem_addr), .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr),
        .o_mem_wdata(o_mem_wdata), .o_acc_wr(o_acc_wr),
        .o_acc_wdata(o_acc_wdata), .o_carry(o_carry),
        .o_negative(o_negative), .o_zero(o_zero),
        .o_status_wr(o_status_wr), .o_indexed(o_indexed), .o_done(o_done));

    // free-running clock, 50 ns period
    initial begin
        i_core_clk = 1'b0;
        forever #25 i_core_clk = ~i_core_clk;
    end

    // one comparison; four-state compare so x never matches
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask : chk

    // single place where the run ends
    task report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : report_and_stop

    // inputs always move 2 ns after the rising edge
    task step;
        @(posedge i_core_clk);
        #2;
    endtask : step

    // one full instruction with expectations worked out here
    task automatic run_op(input logic [7:0] f, input logic d, input logic a,
        input logic x, input logic [3:0] bp, input logic [11:0] ib,
        input logic c, input logic [7:0] data, input logic [11:0] ea,
        input logic ei);
        logic [7:0] res;
        int k;
        res = {c, data[7:1]};
        i_f_operand = f;
        i_dest_sel = d;
        i_bank_sel = a;
        i_ext_set_en = x;
        i_bank_base_ptr = bp;
        i_index_base = ib;
        i_carry = c;
        i_mem_rdata = ~data;
        i_start = 1'b1;
        step;
        i_start = 1'b0;
        k = 0;
        // bounded wait for the read strobe
        while (o_mem_rd !== 1'b1 && k < 8) begin
            step;
            k++;
        end
        if (k == 8) begin
            mismatches++;
            report_and_stop;
        end
        chk(o_mem_addr, ea); // bank resolution
        chk(o_indexed, ei); // indexed flag
        chk(o_busy, 1'b1);
        i_mem_rdata = data; // valid through the cycle after the strobe
        step;
        chk(o_mem_rd, 1'b0);
        step;
        i_mem_rdata = ~data; // no longer the read slot
        chk(o_done, 1'b1); // fixed two edges after read
        chk(o_status_wr, 1'b1);
        chk(o_mem_wr, d); // file write only for d=1
        chk(o_acc_wr, !d); // accumulator only for d=0
        if (d) begin
            chk(o_mem_wdata, res); // rotated byte
            chk(o_mem_addr, ea); // written back in place
        end else begin
            chk(o_acc_wdata, res); // rotated byte
        end
        chk(o_carry, data[0]); // bit 0 into carry
        chk(o_negative, res[7]);
        chk(o_zero, res == 8'h00);
        step;
        chk(o_done, 1'b0);
        chk(o_busy, 1'b0);
        chk(o_mem_wr | o_acc_wr, 1'b0); // single write
    endtask : run_op

    // busy and strobe outputs quiet right after reset
    task sc_after_reset;
        chk(o_busy, 1'b0);
        chk(o_done | o_mem_rd | o_mem_wr | o_acc_wr | o_status_wr,
            1'b0);
    endtask : sc_after_reset

    // result to accumulator, direct bank low half with old carry 0, upper half with old carry 1
    task sc_acc_direct;
        run_op(8'h20, 1'b0, 1'b0, 1'b0, 4'h7, 12'h000, 1'b0, 8'he6, 12'h020,
            1'b0);
        run_op(8'h81, 1'b0, 1'b0, 1'b1, 4'h3, 12'h400, 1'b1, 8'h00, 12'hf81,
            1'b0); // upper half of direct bank
    endtask : sc_acc_direct

    // write back through the bank pointer, carry in set, zero result too
    task sc_file_ptr;
        run_op(8'ha5, 1'b1, 1'b1, 1'b1, 4'h5, 12'h300, 1'b1, 8'h01, 12'h5a5,
            1'b0); // pointer ignores extended set
        run_op(8'h10, 1'b1, 1'b1, 1'b0, 4'hc, 12'h000, 1'b0, 8'h01, 12'hc10,
            1'b0);
    endtask : sc_file_ptr

    // indexed boundary at 5fh and just above, with address wrap
    task sc_indexed_edge;
        run_op(8'h5f, 1'b1, 1'b0, 1'b1, 4'h9, 12'hfb0, 1'b1, 8'h7e, 12'h00f,
            1'b1);
        run_op(8'h00, 1'b0, 1'b0, 1'b1, 4'h9, 12'h123, 1'b0, 8'h55, 12'h123,
            1'b1);
        run_op(8'h60, 1'b0, 1'b0, 1'b1, 4'h9, 12'h123, 1'b1, 8'hff, 12'hf60,
            1'b0);
    endtask : sc_indexed_edge

    // start held high: ignored while busy, one take per five edges
    task sc_held_start;
        int writes;
        writes = 0;
        i_dest_sel = 1'b1;
        i_bank_sel = 1'b1;
        i_mem_rdata = 8'h3c;
        i_start = 1'b1;
        repeat (10) begin
            step;
            if (o_mem_wr === 1'b1) writes++;
        end
        i_start = 1'b0;
        repeat (6) step;
        chk(writes, 2); // one write per instruction
        chk(o_busy, 1'b0);
    endtask : sc_held_start

    // main sequence
    initial begin
        mismatches = 0;
        n_checks = 0;
        i_reset = 1'b1;
        i_start = 1'b0;
        i_f_operand = 8'h00;
        i_dest_sel = 1'b1;
        i_bank_sel = 1'b1;
        i_ext_set_en = 1'b0;
        i_bank_base_ptr = 4'h0;
        i_index_base = 12'h000;
        i_carry = 1'b0;
        i_mem_rdata = 8'h00;
        repeat (20) step;
        i_reset = 1'b0;
        sc_after_reset;
        sc_acc_direct;
        sc_file_ptr;
        sc_indexed_edge;
        sc_held_start;
        report_and_stop;
    end
endmodule : testbench
